// ---- slr_regs.vh ----
/*
  Constants for the four-stage shift/load register.
  Assumes inclusion by the single design file of this block.
*/
`ifndef SLR_REGS_VH
`define SLR_REGS_VH

// Number of storage stages
`define SLR_WIDTH 4
// Stage contents after reset
`define SLR_STAGE_RST 4'h0
// Output buffer entries
`define SLR_BUF_DEPTH 2
// Output buffer occupancy values
`define SLR_CNT_EMPTY 2'h0
`define SLR_CNT_FULL 2'h2

`endif

// ---- slr_shift_load_reg.v ----
/*
  Four-stage register with right shift (serial entry), parallel load and hold,
  updated on the falling edge of the device clock pin. Each new value is also
  pushed into a two-entry output stream buffer.
  Assumes all pin inputs are asynchronous to core_clk_i and that the device
  clock pin is slow enough for its edges to be seen after synchronisation.
*/
`include "slr_regs.vh"
`default_nettype none

module slr_shift_load_reg (
  input wire core_clk_i, // System clock, 100 MHz
  input wire rst_i, // Synchronous reset, active high
  input wire stage_clk_i, // Device clock pin, acts on falling edge
  input wire shift_sel_i, // Shift select level
  input wire load_sel_i, // Load select level
  input wire serial_shift_input_i, // Serial bit for the first stage
  input wire [`SLR_WIDTH-1:0] parallel_load_inputs_i, // Parallel data, bit 0 is first stage
  output wire [`SLR_WIDTH-1:0] stage_o, // Stage outputs, bit 0 is first stage
  output wire out_valid_o, // Buffer holds a word
  output wire [`SLR_WIDTH-1:0] out_data_o, // Oldest buffered register value
  input wire out_ready_i, // Receiver takes the word
  output wire busy_o // Update deferred while buffer full
);

  localparam SYNC_W = 4 + `SLR_WIDTH;

  reg [SYNC_W-1:0] sync1_ff;
  reg [SYNC_W-1:0] sync2_ff;
  reg clk_prev_ff;
  reg pend_ff;
  reg [`SLR_WIDTH-1:0] stage_ff;
  reg [`SLR_WIDTH-1:0] buf_ff [0:`SLR_BUF_DEPTH-1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] cnt_ff;

  reg [`SLR_WIDTH-1:0] nxt_stage;
  reg [1:0] nxt_cnt;
  reg nxt_pend;

  wire clk_s = sync2_ff[SYNC_W-1];
  wire shift_s = sync2_ff[SYNC_W-2];
  wire load_s = sync2_ff[SYNC_W-3];
  wire ser_s = sync2_ff[SYNC_W-4];
  wire [`SLR_WIDTH-1:0] par_s = sync2_ff[`SLR_WIDTH-1:0];

  // Next stage contents; shift has priority over load
  function [`SLR_WIDTH-1:0] f_next_stage;
    input [`SLR_WIDTH-1:0] cur;
    input shift;
    input load;
    input ser;
    input [`SLR_WIDTH-1:0] par;
    begin
      f_next_stage = cur;
      if (shift) begin
        f_next_stage = {cur[`SLR_WIDTH-2:0], ser};
      end else if (load) begin
        f_next_stage = par;
      end
    end
  endfunction

  // Buffer occupancy after a push and a pop in the same cycle
  function [1:0] f_next_cnt;
    input [1:0] cnt;
    input push;
    input take;
    begin
      f_next_cnt = cnt;
      if (push & ~take) begin
        f_next_cnt = cnt + 2'h1;
      end else if (take & ~push) begin
        f_next_cnt = cnt - 2'h1;
      end
    end
  endfunction

  // Buffer has no free entry
  function f_is_full;
    input [1:0] cnt;
    begin
      f_is_full = (cnt == `SLR_CNT_FULL);
    end
  endfunction

  // Buffer holds no word
  function f_is_empty;
    input [1:0] cnt;
    begin
      f_is_empty = (cnt == `SLR_CNT_EMPTY);
    end
  endfunction

  // High to low step of a synchronised level
  function f_fall;
    input prev;
    input cur;
    begin
      f_fall = prev & ~cur;
    end
  endfunction

  wire fall = f_fall(clk_prev_ff, clk_s);
  wire can_push = ~f_is_full(cnt_ff);
  wire pop = out_valid_o & out_ready_i;
  wire go = (fall | pend_ff) & can_push;

  // First synchroniser stage for every pin input
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_ff <= {SYNC_W{1'h0}};
    end else begin
      sync1_ff <= {stage_clk_i, shift_sel_i, load_sel_i, serial_shift_input_i,
                   parallel_load_inputs_i};
    end
  end

  // Second synchroniser stage; only this stage is read by logic
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sync2_ff <= {SYNC_W{1'h0}};
    end else begin
      sync2_ff <= sync1_ff;
    end
  end

  // Previous synchronised clock pin level for edge detection
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      clk_prev_ff <= 1'h0;
    end else begin
      clk_prev_ff <= clk_s;
    end
  end

  always @* begin
    nxt_stage = f_next_stage(stage_ff, shift_s, load_s, ser_s, par_s);
  end

  always @* begin
    nxt_cnt = f_next_cnt(cnt_ff, go, pop);
  end

  // An edge seen while the buffer is full waits for space
  always @* begin
    nxt_pend = (fall | pend_ff) & ~can_push;
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      stage_ff <= `SLR_STAGE_RST;
    end else if (go) begin
      stage_ff <= nxt_stage;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_ff <= 1'h0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      buf_ff[0] <= `SLR_STAGE_RST;
      buf_ff[1] <= `SLR_STAGE_RST;
    end else if (go) begin
      buf_ff[wr_ptr_ff] <= nxt_stage;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= 1'h0;
    end else if (go) begin
      wr_ptr_ff <= ~wr_ptr_ff;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_ptr_ff <= 1'h0;
    end else if (pop) begin
      rd_ptr_ff <= ~rd_ptr_ff;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_ff <= `SLR_CNT_EMPTY;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign stage_o = stage_ff;
  assign out_valid_o = ~f_is_empty(cnt_ff);
  assign out_data_o = buf_ff[rd_ptr_ff];
  assign busy_o = pend_ff;

endmodule

`default_nettype wire

// ---- slr_monitor.sv ----
/* Checker on the top-level ports of the shift/load register.
   Assumes the device clock pin idles high through reset and holds each level
   for at least three system clock cycles; an update lands two edges after
   the pin is first sampled low. */
`default_nettype none
module slr_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic stage_clk_i,
  input wire logic shift_sel_i,
  input wire logic load_sel_i,
  input wire logic serial_shift_input_i,
  input wire logic [3:0] parallel_load_inputs_i,
  input wire logic [3:0] stage_o,
  input wire logic out_valid_o,
  input wire logic [3:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic busy_o
);
  chk_shift_in: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(stage_clk_i,2) && $past(stage_clk_i,3) && !busy_o && $past(shift_sel_i,2) |=>
    busy_o || stage_o == {$past(stage_o[2:0]), $past(serial_shift_input_i,3)})
    else $error("shift result wrong");
  chk_par_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(stage_clk_i,2) && $past(stage_clk_i,3) && !busy_o && !$past(shift_sel_i,2) &&
    $past(load_sel_i,2) |=> busy_o || stage_o == $past(parallel_load_inputs_i,3))
    else $error("parallel load wrong");
  chk_hold_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(stage_clk_i,2) && $past(stage_clk_i,3) && !busy_o && !$past(shift_sel_i,2) &&
    !$past(load_sel_i,2) |=> $stable(stage_o))
    else $error("hold changed stages");
  chk_no_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(!$past(stage_clk_i,2) && $past(stage_clk_i,3)) && !busy_o |=> $stable(stage_o))
    else $error("stages changed without edge");
  chk_word_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("stalled word changed");
  chk_busy_full: assert property (@(posedge core_clk_i) disable iff (rst_i)
    busy_o |-> out_valid_o)
    else $error("busy with empty buffer");
  chk_edge_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(stage_clk_i,2) && $past(stage_clk_i,3) && !busy_o |=> out_valid_o)
    else $error("update not buffered");
endmodule
bind slr_shift_load_reg slr_chk u_chk(.*);
`default_nettype wire

// ---- slr_proc_model.sv ----
/* Far side: stage clock pin and a receiver that stalls on hold_i. */
`default_nettype none
module slr_proc_model(input wire logic core_clk_i, rst_i, hold_i,
  output logic stage_clk_o = 1'h1, out_ready_o = 1'h0);
  logic [2:0] cnt_ff;
  always @(negedge core_clk_i) begin
    cnt_ff <= rst_i ? 3'h0 : cnt_ff + 3'h1;
    if (cnt_ff == 3'h7) stage_clk_o <= ~stage_clk_o;
    out_ready_o <= !hold_i;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/* Bench top; slr_proc_model is the far side. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, rst_i = 1, shift_sel_i = 0, load_sel_i = 0, hold_i = 0;
  logic serial_shift_input_i = 0, stage_clk_i, out_ready_i, out_valid_o, busy_o;
  logic [3:0] parallel_load_inputs_i = 0, stage_o, out_data_o, e = 0;
  logic [3:0] exp_q [0:63];
  int n_errors = 0, checks = 0, n_pop = 0;
  always #5 core_clk_i = ~core_clk_i;
  slr_proc_model i_prt(.*, .stage_clk_o(stage_clk_i), .out_ready_o(out_ready_i));
  slr_shift_load_reg i_dut(.*);
  function automatic logic [3:0] exp_next(logic [3:0] cur, logic sh, ld, ser,
                                          logic [3:0] par);
    if (sh) return {cur[2:0], ser};
    if (ld) return par;
    return cur;
  endfunction
  // Every update is one stream word, in order
  always @(posedge core_clk_i) begin
    if (!rst_i && out_valid_o && out_ready_i) begin
      chk(out_data_o, exp_q[n_pop[5:0]]);
      n_pop++;
    end
  end
  task automatic chk(logic [3:0] seen, exp);
    checks++;
    if (seen !== exp) $display("BAD %0t %h %h", $time, seen, exp);
    n_errors += seen !== exp;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000 n_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h233B));
    repeat (5) @(negedge core_clk_i);
    rst_i = 0;
    for (int i = 0; i < 40; i++) begin
      {shift_sel_i, load_sel_i} = 2'(i < 4 ? i : $urandom);
      {serial_shift_input_i, parallel_load_inputs_i} = 5'($urandom);
      if (i == 20) hold_i = 1;
      e = exp_next(e, shift_sel_i, load_sel_i, serial_shift_input_i, parallel_load_inputs_i);
      exp_q[i] = e;
      @(posedge stage_clk_i);
      @(negedge core_clk_i);
      if (i == 22) chk({3'h0, busy_o}, 4'h1);
      if (i == 22) hold_i = 0;
      repeat (5) @(negedge core_clk_i);
      chk(stage_o, e);
    end
    chk({3'h0, n_pop == 40}, 4'h1);
    end_sim;
  end
endmodule
`default_nettype wire
